// File: bench/lisms_partner.sv
// system side model: drives the tx rails and the rx sink ready
`timescale 1ns/1ps
module lisms_partner (
  // controls from the bench
  input  wire logic mclk,
  input  wire logic pulse_neg,
  input  wire logic pos_val,
  input  wire logic neg_val,
  input  wire logic data_val,
  input  wire logic stall,
  // system side pins
  output logic      tx_clock_in,
  output logic      tx_pos_rail_in,
  output logic      tx_neg_rail_in,
  output logic      tx_single_data_in,
  output logic      rx_sink_ready
);
  // ------------------------------------------------------------
  // free running tx clock, phase unrelated to mclk
  // ------------------------------------------------------------
  initial begin
    tx_clock_in       = 1'b0;
    tx_pos_rail_in    = 1'b0;
    tx_neg_rail_in    = 1'b0;
    tx_single_data_in = 1'b0;
    rx_sink_ready     = 1'b1;
    #37;
    forever #200 tx_clock_in = ~tx_clock_in;
  end

  // data moves on the rise so it is steady at the sampling fall
  always @(posedge tx_clock_in) begin
    tx_pos_rail_in    <= pos_val;
    tx_single_data_in <= data_val;
    tx_neg_rail_in    <= pulse_neg ? ~tx_neg_rail_in : neg_val;
  end

  always @(posedge mclk) begin
    rx_sink_ready <= ~stall;
  end
endmodule

// File: bench/testbench.sv
// self-checking bench for the mode select channel
`timescale 1ns/1ps
`define chk(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("unexpected at %0t got %h expected %h", $time, (got), (exp)); \
    end \
  end
module testbench;
  import lisms_pkg::*;
  logic       mclk = 1'b0, reset = 1'b1, host_mode = 1'b0;
  logic [2:0] template_select_pins = 3'h4, template_select_reg = 3'h0;
  logic       recovery_select_bit = 1'b0, single_rail_select_bit = 1'b0;
  logic       code_ami_sel = 1'b0, edge_select_pin = 1'b1, master_clock_pin = 1'b0;
  logic       slicer_pos_in = 1'b0, slicer_neg_in = 1'b0;
  logic       host_serial_clock_in = 1'b0, host_serial_in = 1'b0;
  logic       pulse_neg = 1'b1, pos_val = 1'b0, neg_val = 1'b0;
  logic       data_val = 1'b0, stall = 1'b0;
  logic [1:0] mclk_pin_sel = 2'h0;
  logic       tx_clock_in, tx_pos_rail_in, tx_neg_rail_in, tx_single_data_in;
  logic       rx_sink_ready, rx_buf_ready, rx_pos_rail_out, rx_neg_rail_out;
  logic       rx_recovered_clock_out, rx_single_data_out, code_violation_out;
  logic       line_tx_tip, line_tx_ring, host_serial_out, e1_mode, prev_tip;
  logic [7:0] host_serial_word;
  logic [2:0] mode_status;
  logic [2:0] host_exp [4] = '{3'h0, 3'h1, 3'h3, 3'h0};
  int         mismatches = 0, checked = 0, viol, pos_seen, neg_seen, clk_rises;

  always #25 mclk = ~mclk;

  // master clock pin: running, tied high or tied low
  always @(posedge mclk) begin
    if (mclk_pin_sel == 2'h0) master_clock_pin <= ~master_clock_pin;
    else master_clock_pin <= (mclk_pin_sel == 2'h1);
  end

  lisms_channel i_lisms_channel (.mclk(mclk), .reset(reset), .host_mode(host_mode),
    .template_select_pins(template_select_pins), .template_select_reg(template_select_reg),
    .recovery_select_bit(recovery_select_bit),
    .single_rail_select_bit(single_rail_select_bit), .code_ami_sel(code_ami_sel),
    .edge_select_pin(edge_select_pin), .master_clock_pin(master_clock_pin),
    .tx_clock_in(tx_clock_in), .tx_pos_rail_in(tx_pos_rail_in),
    .tx_neg_rail_in(tx_neg_rail_in), .tx_single_data_in(tx_single_data_in),
    .slicer_pos_in(slicer_pos_in), .slicer_neg_in(slicer_neg_in),
    .line_tx_tip(line_tx_tip), .line_tx_ring(line_tx_ring),
    .rx_sink_ready(rx_sink_ready), .rx_buf_ready(rx_buf_ready),
    .rx_pos_rail_out(rx_pos_rail_out), .rx_neg_rail_out(rx_neg_rail_out),
    .rx_recovered_clock_out(rx_recovered_clock_out),
    .rx_single_data_out(rx_single_data_out), .code_violation_out(code_violation_out),
    .host_serial_clock_in(host_serial_clock_in), .host_serial_in(host_serial_in),
    .host_serial_out(host_serial_out), .host_serial_word(host_serial_word),
    .mode_status(mode_status), .e1_mode(e1_mode));

  lisms_partner i_lisms_partner (.mclk(mclk), .pulse_neg(pulse_neg), .pos_val(pos_val),
    .neg_val(neg_val), .data_val(data_val), .stall(stall), .tx_clock_in(tx_clock_in),
    .tx_pos_rail_in(tx_pos_rail_in), .tx_neg_rail_in(tx_neg_rail_in),
    .tx_single_data_in(tx_single_data_in), .rx_sink_ready(rx_sink_ready));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // lands mid bit: outputs move about 3 mclk after the tx fall
  task automatic txc(input int n);
    repeat (n) @(negedge tx_clock_in);
    wt(6);
  endtask

  // marks on the positive slicer at about the T1 bit rate
  task automatic send_marks(input int n);
    repeat (n) begin
      for (int k = 0; k < 13; k++) begin
        @(posedge mclk);
        slicer_pos_in <= (k < 6);
        #1;
        if (rx_pos_rail_out === 1'b1) pos_seen++;
        if (rx_neg_rail_out === 1'b1) neg_seen++;
        if (rx_recovered_clock_out === 1'b1 && k == 0) clk_rises++;
      end
    end
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #1_000_000;
    mismatches++;
    tally_and_finish;
  end

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    wt(1);
    `chk(rx_buf_ready, 1'b1)
    wt(6);
    `chk(mode_status, 3'h0)
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      host_mode            <= i[3];
      template_select_pins <= i[2:0];
      template_select_reg  <= ~i[2:0];
      wt(8);
      `chk(e1_mode, i[3] ? (i[2:0] >= 3'h4) : (i[2:0] < 3'h4))
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      recovery_select_bit    <= i[0];
      single_rail_select_bit <= i[1];
      wt(8);
      `chk(mode_status, host_exp[i])
    end
    // static pin needs the idle timeout before it counts
    @(posedge mclk);
    single_rail_select_bit <= 1'b1;
    mclk_pin_sel           <= 2'h1;
    wt(60);
    `chk(mode_status, 3'h1)
    @(posedge mclk);
    mclk_pin_sel <= 2'h2;
    wt(60);
    `chk(mode_status, 3'h4)
    @(posedge mclk);
    mclk_pin_sel           <= 2'h0;
    single_rail_select_bit <= 1'b0;
    recovery_select_bit    <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      edge_select_pin <= i[2];
      slicer_pos_in   <= i[0];
      slicer_neg_in   <= i[1];
      wt(8);
      `chk(rx_pos_rail_out, i[0] ^ ~i[2])
      `chk(rx_neg_rail_out, i[1] ^ ~i[2])
      `chk(rx_recovered_clock_out, i[0] ^ i[1])
    end
    @(posedge mclk);
    recovery_select_bit <= 1'b0;
    edge_select_pin     <= 1'b1;
    slicer_pos_in       <= 1'b0;
    slicer_neg_in       <= 1'b0;
    pulse_neg           <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      pos_val      <= i[0];
      neg_val      <= i[1];
      code_ami_sel <= i[0];
      txc(3);
      `chk(line_tx_tip, i[0])
      `chk(line_tx_ring, i[1])
    end
    `chk(mode_status, 3'h0)
    // held rail in hardware mode, count started from a low sample
    @(posedge mclk);
    host_mode <= 1'b0;
    neg_val   <= 1'b0;
    txc(2);
    @(posedge mclk);
    neg_val <= 1'b1;
    txc(12);
    `chk(mode_status, 3'h0)
    txc(8);
    `chk(mode_status, 3'h2)
    @(posedge mclk);
    pulse_neg <= 1'b1;
    txc(4);
    `chk(mode_status, 3'h0)
    @(posedge mclk);
    pulse_neg <= 1'b0;
    txc(10);
    @(posedge mclk);
    neg_val <= 1'b0;
    txc(1);
    @(posedge mclk);
    neg_val <= 1'b1;
    txc(10);
    `chk(mode_status, 3'h0)
    // single rail mode 2 with AMI, all ones
    @(posedge mclk);
    neg_val                <= 1'b0;
    host_mode              <= 1'b1;
    single_rail_select_bit <= 1'b1;
    code_ami_sel           <= 1'b1;
    data_val               <= 1'b1;
    txc(12);
    `chk(mode_status, 3'h3)
    prev_tip = line_tx_tip;
    for (int j = 0; j < 6; j++) begin
      txc(1);
      `chk(line_tx_tip ^ line_tx_ring, 1'b1)
      `chk(line_tx_tip, ~prev_tip)
      prev_tip = line_tx_tip;
    end
    @(posedge mclk);
    neg_val <= 1'b1;
    txc(1);
    prev_tip = line_tx_tip;
    @(posedge mclk);
    neg_val <= 1'b0;
    viol = 0;
    for (int j = 0; j < 12; j++) begin
      txc(1);
      if (line_tx_tip === prev_tip) viol++;
      prev_tip = line_tx_tip;
    end
    `chk(viol != 0, 1'b1)
    // zero substitution: all zeros must still put pulses on the line
    @(posedge mclk);
    code_ami_sel <= 1'b0;
    data_val     <= 1'b0;
    txc(12);
    viol = 0;
    for (int j = 0; j < 16; j++) begin
      txc(1);
      viol += line_tx_tip | line_tx_ring;
    end
    `chk(viol != 0, 1'b1)
    // receive path with the sink stalled, then draining
    @(posedge mclk);
    single_rail_select_bit <= 1'b0;
    template_select_reg    <= 3'h4;
    pulse_neg              <= 1'b1;
    stall                  <= 1'b1;
    send_marks(40);
    `chk(rx_buf_ready, 1'b0)
    @(posedge mclk);
    stall     <= 1'b0;
    pos_seen  = 0;
    neg_seen  = 0;
    clk_rises = 0;
    send_marks(30);
    `chk(rx_buf_ready, 1'b1)
    `chk(pos_seen != 0, 1'b1)
    `chk(neg_seen, 0)
    `chk(clk_rises != 0, 1'b1)
    for (int b = 7; b >= 0; b--) begin
      @(posedge mclk);
      host_serial_in <= b[0] ^ b[1] ^ 1'b1;
      wt(4);
      @(posedge mclk);
      host_serial_clock_in <= 1'b1;
      wt(4);
      @(posedge mclk);
      host_serial_clock_in <= 1'b0;
      wt(4);
      `chk(host_serial_out, b == 2)
    end
    wt(6);
    `chk(host_serial_word, 8'h99)
    // single rail receive: same polarity marks are violations
    @(posedge mclk);
    single_rail_select_bit <= 1'b1;
    send_marks(20);
    `chk(rx_single_data_out, 1'b1)
    `chk(code_violation_out, 1'b1)
    `chk(rx_pos_rail_out, 1'b0)
    tally_and_finish;
  end
endmodule

// File: src/lisms_channel.sv
`timescale 1ns/1ps
// one channel: system side mode select, line coding and receive data path
module lisms_channel
  import lisms_pkg::*;
#(
  parameter int BUF_W     = 4,
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // control pins and per-channel bits
  input  wire logic       host_mode,
  input  wire logic [2:0] template_select_pins,
  input  wire logic [2:0] template_select_reg,
  input  wire logic       recovery_select_bit,
  input  wire logic       single_rail_select_bit,
  input  wire logic       code_ami_sel,
  input  wire logic       edge_select_pin,
  input  wire logic       master_clock_pin,
  // system transmit side
  input  wire logic       tx_clock_in,
  input  wire logic       tx_pos_rail_in,
  input  wire logic       tx_neg_rail_in,
  input  wire logic       tx_single_data_in,
  // line side
  input  wire logic       slicer_pos_in,
  input  wire logic       slicer_neg_in,
  output logic            line_tx_tip,
  output logic            line_tx_ring,
  // system receive side
  input  wire logic       rx_sink_ready,
  output logic            rx_buf_ready,
  output logic            rx_pos_rail_out,
  output logic            rx_neg_rail_out,
  output logic            rx_recovered_clock_out,
  output logic            rx_single_data_out,
  output logic            code_violation_out,
  // host serial
  input  wire logic       host_serial_clock_in,
  input  wire logic       host_serial_in,
  output logic            host_serial_out,
  output logic [7:0]      host_serial_word,
  // status
  output logic [2:0]      mode_status,
  output logic            e1_mode
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  localparam int NS = 15;
  localparam int AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  wire [NS-1:0] pins_raw = {master_clock_pin, tx_clock_in, tx_pos_rail_in,
    tx_neg_rail_in, tx_single_data_in, slicer_pos_in, slicer_neg_in,
    host_serial_clock_in, host_serial_in, template_select_pins,
    edge_select_pin, host_mode, code_ami_sel};
  logic [NS-1:0] sy1, sy2;
  logic          mck_s, tck_s, tdp_s, tdn_s, tds_s, sp_s, sn_s;
  logic          sck_s, sdi_s, edge_select_pin_s, host_s, ami_s;
  logic [2:0]    ts_s;
  always_ff @(posedge mclk) begin
    if (reset) begin
      sy1 <= '0;
      sy2 <= '0;
    end else begin
      sy1 <= pins_raw;
      sy2 <= sy1;
    end
  end
  assign {mck_s, tck_s, tdp_s, tdn_s, tds_s, sp_s, sn_s, sck_s, sdi_s, ts_s,
          edge_select_pin_s, host_s, ami_s} = sy2;

  logic mck_d, tck_d, sck_d, pls_d;
  always_ff @(posedge mclk) begin
    if (reset) begin
      {mck_d, tck_d, sck_d, pls_d} <= 4'h0;
    end else begin
      {mck_d, tck_d, sck_d, pls_d} <= {mck_s, tck_s, sck_s, sp_s | sn_s};
    end
  end
  wire tclk_fall = tck_d & ~tck_s;
  wire sclk_rise = ~sck_d & sck_s;
  wire sclk_act  = edge_select_pin_s ? (sck_d & ~sck_s) : sclk_rise;

  // ----------------------------------------------------------------------
  // master clock activity and held rail detection
  // ----------------------------------------------------------------------
  logic [7:0] idle;
  logic [4:0] tdn_cnt;
  wire mclk_run = idle < MCLK_IDLE_CYC;
  wire held     = tdn_cnt > HELD_HIGH_EDGES;
  wire [4:0] tdn_inc = held ? tdn_cnt : tdn_cnt + 5'h01;
  always_ff @(posedge mclk) begin
    if (reset) begin
      idle    <= 8'h00;
      tdn_cnt <= 5'h00;
    end else begin
      idle <= (mck_s ^ mck_d) ? 8'h00 : (mclk_run ? idle + 8'h01 : idle);
      if (tclk_fall) begin
        tdn_cnt <= tdn_s ? tdn_inc : 5'h00; // RL7 RL21
      end
    end
  end

  // ----------------------------------------------------------------------
  // mode select
  // ----------------------------------------------------------------------
  lisms_mode_t mode, next_mode, run_mode;
  wire [2:0] ts_sel = host_s ? template_select_reg : ts_s;
  wire       e1     = ts_sel < TS_T1_FIRST; // RL1
  always_comb begin
    case ({recovery_select_bit, single_rail_select_bit})
      2'b01:   run_mode = LISMS_SR2; // RL8 RL10
      2'b10:   run_mode = LISMS_DUAL_RAW; // RL10
      default: run_mode = held ? LISMS_SR1 : LISMS_DUAL_CR; // RL10
    endcase
    if (!mclk_run) begin
      next_mode = mck_s ? LISMS_DUAL_RAW : LISMS_PWRDN; // RL9 RL11
    end else if (!host_s) begin
      next_mode = held ? LISMS_SR1 : LISMS_DUAL_CR; // RL9
    end else begin
      next_mode = run_mode; // RL2
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      mode <= MODE_RST; // RL4
    end else begin
      mode <= next_mode;
    end
  end
  wire single = (mode == LISMS_SR1) | (mode == LISMS_SR2);
  wire coding = single & ~ami_s; // RL20

  // ----------------------------------------------------------------------
  // transmit encoder: eight bit window, substitutions marked as they enter
  // ----------------------------------------------------------------------
  logic [7:0]      enc_d;
  logic [7:0][1:0] enc_c, next_enc_c;
  logic            tx_pol, tx_odd;
  logic [7:0]      enc_nz;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_nz
      assign enc_nz[gi] = enc_c[gi] != LISMS_SYM_DATA;
    end
  endgenerate
  wire b8_hit = coding & ~e1 & ~tds_s & (enc_d[6:0] == 7'h00) &
                (enc_nz[6:0] == 7'h00);
  wire hd_hit = coding & e1 & ~tds_s & (enc_d[2:0] == 3'h0) &
                (enc_nz[2:0] == 3'h0);
  always_comb begin
    next_enc_c = {enc_c[6:0], LISMS_SYM_DATA};
    if (b8_hit) begin
      next_enc_c[0] = LISMS_SYM_BIP;
      next_enc_c[1] = LISMS_SYM_VIOL;
      next_enc_c[3] = LISMS_SYM_BIP;
      next_enc_c[4] = LISMS_SYM_VIOL;
    end else if (hd_hit) begin
      next_enc_c[0] = LISMS_SYM_VIOL;
      next_enc_c[3] = LISMS_SYM_CBIP;
    end
  end
  // in mode 2 the negative rail pin doubles as the violation insert input
  wire bipolar_violation_insert_in = tdn_s;
  wire bpv  = (mode == LISMS_SR2) & ami_s & bipolar_violation_insert_in; // RL8
  wire [1:0] oc = enc_c[7];
  wire tx_v = (oc == LISMS_SYM_VIOL) | bpv;
  wire tx_b = ~tx_v & ((oc == LISMS_SYM_BIP) | ((oc == LISMS_SYM_CBIP) & ~tx_odd) |
              ((oc == LISMS_SYM_DATA) & enc_d[7]));
  wire tx_p = tx_v ? tx_pol : ~tx_pol;
  always_ff @(posedge mclk) begin
    if (reset) begin
      enc_d       <= 8'h00;
      enc_c       <= '0;
      tx_pol      <= 1'b0;
      tx_odd      <= 1'b0;
      line_tx_tip  <= 1'b0;
      line_tx_ring <= 1'b0;
    end else if (tclk_fall) begin // RL16
      enc_d <= {enc_d[6:0], tds_s};
      enc_c <= next_enc_c; // RL6
      if (single) begin
        line_tx_tip  <= (tx_v | tx_b) & tx_p; // RL6
        line_tx_ring <= (tx_v | tx_b) & ~tx_p;
        tx_pol       <= (tx_v | tx_b) ? tx_p : tx_pol;
        tx_odd       <= tx_v ? 1'b0 : tx_odd ^ tx_b;
      end else begin
        line_tx_tip  <= tdp_s; // RL3 RL20
        line_tx_ring <= tdn_s;
      end
    end
  end

  // ----------------------------------------------------------------------
  // clock recovery: phase accumulator stepped each mclk, one overflow per bit
  // ----------------------------------------------------------------------
  logic [NCO_W-1:0] acc;
  logic             seen_p, seen_n;
  wire [NCO_W:0] acc_sum = {1'b0, acc} + {1'b0, e1 ? NCO_INC_E1 : NCO_INC_T1}; // RL19
  wire pls_rise = (sp_s | sn_s) & ~pls_d;
  wire strobe   = acc_sum[NCO_W] & ~pls_rise;
  wire [NCO_W-1:0] next_acc = pls_rise ? NCO_CENTER : acc_sum[NCO_W-1:0];
  always_ff @(posedge mclk) begin
    if (reset) begin
      acc    <= '0;
      seen_p <= 1'b0;
      seen_n <= 1'b0;
    end else begin
      acc    <= next_acc;
      seen_p <= (seen_p & ~strobe) | sp_s;
      seen_n <= (seen_n & ~strobe) | sn_s;
    end
  end

  // ----------------------------------------------------------------------
  // receive decoder window and two-entry buffer
  // ----------------------------------------------------------------------
  logic [7:0] dm, dv, dp;
  logic       rx_pol;
  logic [BUF_W-1:0] buf_q [BUF_DEPTH];
  logic [AW-1:0]    wp, rp;
  logic [AW:0]      cnt;
  wire buf_full  = cnt == (AW+1)'(BUF_DEPTH);
  wire buf_empty = cnt == '0;
  wire r_pls  = seen_p | seen_n;
  wire r_viol = r_pls & (seen_p == rx_pol); // RL18
  wire hd_clr = coding & e1 & r_viol & ~dm[1] & ~dm[0];
  wire b8_clr = coding & ~e1 & r_pls & ~r_viol & dv[0] & ~dm[1] & dm[2] &
                ~dv[2] & dv[3] & (dm[6:4] == 3'h0);
  wire [7:0] clr = hd_clr ? CLR_HDB3 : (b8_clr ? CLR_B8ZS : 8'h00); // RL6 RL17
  wire push = strobe & ~buf_full;
  wire pop  = strobe & rx_sink_ready & ~buf_empty;
  wire [BUF_W-1:0] entry = {dm[7], single & dv[7], dm[7] & dp[7], dm[7] & ~dp[7]};
  wire [BUF_W-1:0] head  = buf_q[rp];
  always_ff @(posedge mclk) begin
    if (reset) begin
      dm     <= 8'h00;
      dv     <= 8'h00;
      dp     <= 8'h00;
      rx_pol <= 1'b0;
      wp     <= '0;
      rp     <= '0;
      cnt    <= '0;
    end else begin
      if (push) begin // window holds while the buffer is full
        dm     <= {dm[6:0], r_pls} & ~clr;
        dv     <= {dv[6:0], r_viol} & ~clr;
        dp     <= {dp[6:0], seen_p};
        rx_pol <= r_pls ? seen_p : rx_pol;
        buf_q[wp] <= entry;
        wp <= (wp == AW'(BUF_DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(BUF_DEPTH - 1)) ? '0 : rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // ----------------------------------------------------------------------
  // receive outputs
  // ----------------------------------------------------------------------
  wire raw_p = sp_s;
  wire raw_n = sn_s;
  wire pd    = mode == LISMS_PWRDN;
  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_pos_rail_out        <= 1'b0;
      rx_neg_rail_out        <= 1'b0;
      rx_recovered_clock_out <= 1'b0;
      rx_single_data_out     <= 1'b0;
      code_violation_out     <= 1'b0;
      rx_buf_ready           <= 1'b1;
    end else begin
      rx_buf_ready <= ~buf_full | pop;
      if (pd) begin
        {rx_pos_rail_out, rx_neg_rail_out, rx_recovered_clock_out} <= 3'h0;
        {rx_single_data_out, code_violation_out} <= 2'h0;
      end else if (mode == LISMS_DUAL_RAW) begin
        rx_pos_rail_out        <= raw_p ^ ~edge_select_pin_s; // RL5 RL14
        rx_neg_rail_out        <= raw_n ^ ~edge_select_pin_s;
        rx_recovered_clock_out <= raw_p ^ raw_n; // RL5
      end else begin
        rx_recovered_clock_out <= next_acc[NCO_W-1] ^ edge_select_pin_s; // RL12
        if (pop) begin // RL13
          rx_single_data_out <= single & head[3]; // RL17
          code_violation_out <= head[2];
          rx_pos_rail_out    <= ~single & head[1];
          rx_neg_rail_out    <= ~single & head[0];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // host serial shifter and status
  // ----------------------------------------------------------------------
  logic [7:0] sdo_sh;
  logic [2:0] sdo_bit;
  always_ff @(posedge mclk) begin
    if (reset) begin
      host_serial_word <= 8'h00;
      host_serial_out  <= 1'b0;
      sdo_sh           <= 8'h00;
      sdo_bit          <= 3'h0;
      mode_status      <= MODE_RST;
      e1_mode          <= 1'b0;
    end else begin
      mode_status <= mode;
      e1_mode     <= e1;
      if (sclk_rise) begin
        host_serial_word <= {host_serial_word[6:0], sdi_s}; // RL15
      end
      if (sclk_act) begin // RL12 RL13
        host_serial_out <= (sdo_bit == 3'h0) ? e1 : sdo_sh[7];
        sdo_sh  <= (sdo_bit == 3'h0) ? {mode, held, mclk_run, 3'h0} : sdo_sh << 1;
        sdo_bit <= sdo_bit + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_reset_mode; // RL4
    @(posedge mclk) $fell(reset) |-> mode == LISMS_DUAL_CR;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode not dual after reset"); // RL4

  property p_sr1_entry; // RL7
    @(posedge mclk) disable iff (reset)
      (held && mclk_run && !(host_s && (recovery_select_bit || single_rail_select_bit)))
      |=> mode == LISMS_SR1;
  endproperty
  a_sr1_entry: assert property (p_sr1_entry) else $error("held rail not mode 1"); // RL7

  property p_held_restart; // RL21
    @(posedge mclk) disable iff (reset) (tclk_fall && !tdn_s) |=> !held && tdn_cnt == 5'h00;
  endproperty
  a_held_restart: assert property (p_held_restart) else $error("count not restarted"); // RL21

  property p_mclk_high; // RL11
    @(posedge mclk) disable iff (reset) (!mclk_run && mck_s) |=> mode == LISMS_DUAL_RAW;
  endproperty
  a_mclk_high: assert property (p_mclk_high) else $error("mclk high not raw"); // RL11

  property p_sr2; // RL10
    @(posedge mclk) disable iff (reset)
      (host_s && mclk_run && !recovery_select_bit && single_rail_select_bit)
      |=> mode == LISMS_SR2;
  endproperty
  a_sr2: assert property (p_sr2) else $error("select bits not mode 2"); // RL10

  property p_raw_xor; // RL5
    @(posedge mclk) disable iff (reset)
      mode == LISMS_DUAL_RAW |=> rx_recovered_clock_out == ($past(raw_p) ^ $past(raw_n));
  endproperty
  a_raw_xor: assert property (p_raw_xor) else $error("raw clock not xor"); // RL5

  property p_raw_pol; // RL14
    @(posedge mclk) disable iff (reset)
      mode == LISMS_DUAL_RAW |=> rx_pos_rail_out == ($past(raw_p) ^ !$past(edge_select_pin_s));
  endproperty
  a_raw_pol: assert property (p_raw_pol) else $error("raw rail polarity wrong"); // RL14

  property p_dual_tx; // RL3
    @(posedge mclk) disable iff (reset)
      (tclk_fall && !single) |=> line_tx_tip == $past(tdp_s) && line_tx_ring == $past(tdn_s);
  endproperty
  a_dual_tx: assert property (p_dual_tx) else $error("dual tx rails wrong"); // RL3

  property p_rclk_edge; // RL12
    @(posedge mclk) disable iff (reset)
      (strobe && !pd && mode != LISMS_DUAL_RAW) |=> rx_recovered_clock_out == $past(edge_select_pin_s);
  endproperty
  a_rclk_edge: assert property (p_rclk_edge) else $error("rx clock edge wrong"); // RL12

endmodule

// File: src/lisms_pkg.sv
// constants and types for the line interface mode select channel
package lisms_pkg;
  // Functional notes
  // RL1: T1 or E1 chosen globally, from template pins or template register.
  // RL2: each channel: single rail, dual rail recovered, or dual rail raw slicing.
  // RL3: dual rail: tx rails drive the line pair; rx rails plus recovered clock.
  // RL4: after reset the channel runs dual rail with clock recovery.
  // RL5: raw mode: slicer pulses on the rx rails, their xor on rx clock.
  // RL6: single rail: one data pin each way, line coding, violations flagged.
  // RL7: negative tx rail high over 16 tx clocks enters single rail mode 1.
  // RL8: single rail mode 2: negative tx rail inserts a violation under AMI.
  // RL9: hardware mode: master clock pin state and held rail pick the mode.
  // RL10: host mode, clock running: select bits pick mode 2, recovered or raw.
  // RL11: host mode: master clock high forces raw, low powers receiver down.
  // RL12: edge select high: rx clock rising and serial clock falling active.
  // RL13: rx outputs active high on rx clock edge; serial out likewise.
  // RL14: raw mode: edge select sets polarity of the slicer rail outputs.
  // RL15: serial input sampled on rising serial clock edges.
  // RL16: tx data and violation input sampled on falling tx clock edges.
  // RL17: single rail decodes; dual rail recovered gives undecoded NRZ rails.
  // RL18: receiver detects alarms, violations and codes; changes may interrupt. Code detects violations and codes only; no alarms or interrupt.
  // RL19: recovery loop runs at sixteen times the line rate. Code steps its accumulator once per 20 MHz mclk instead.
  // RL20: dual rail modes bypass the line encoder and decoder.
  // RL21: held-rail count restarts on a low sample; pulses leave mode 1.

  localparam int MCLK_HZ         = 20_000_000;
  localparam int MCLK_PERIOD_NS  = 50;
  localparam int DPLL_OVERSAMPLE = 16;
  localparam int DPLL_HZ_T1      = 24_704_000;
  localparam int DPLL_HZ_E1      = 32_768_000;
  localparam int NCO_W           = 20;
  localparam logic [NCO_W-1:0] NCO_INC_T1 =
    NCO_W'((64'(DPLL_HZ_T1) << NCO_W) / (64'(DPLL_OVERSAMPLE) * 64'(MCLK_HZ)));
  localparam logic [NCO_W-1:0] NCO_INC_E1 =
    NCO_W'((64'(DPLL_HZ_E1) << NCO_W) / (64'(DPLL_OVERSAMPLE) * 64'(MCLK_HZ)));
  localparam logic [NCO_W-1:0] NCO_CENTER = 20'h80000;
  localparam logic [4:0] HELD_HIGH_EDGES = 5'h10;
  localparam int MCLK_IDLE_NS = 2000;
  localparam logic [7:0] MCLK_IDLE_CYC =
    8'((MCLK_IDLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [2:0] TS_T1_FIRST = 3'h4;
  localparam logic [7:0] CLR_HDB3 = 8'h0f;
  localparam logic [7:0] CLR_B8ZS = 8'hff;

  typedef enum logic [2:0] {
    LISMS_DUAL_CR  = 3'b000,
    LISMS_DUAL_RAW = 3'b001,
    LISMS_SR1      = 3'b010,
    LISMS_SR2      = 3'b011,
    LISMS_PWRDN    = 3'b100
  } lisms_mode_t;
  localparam lisms_mode_t MODE_RST = LISMS_DUAL_CR;

  typedef enum logic [1:0] {
    LISMS_SYM_DATA = 2'b00,
    LISMS_SYM_BIP  = 2'b01,
    LISMS_SYM_VIOL = 2'b10,
    LISMS_SYM_CBIP = 2'b11
  } lisms_sym_t;
endpackage
